// *** design/flash_protection_boot_map.sv ***
// flash protection, nonvolatile bits and boot address map
`timescale 1ns/1ps
`default_nettype none
module flash_protection_boot_map #(
  parameter int LOCK_BITS = 16,
  parameter int NUM_PLANES = 1,
  parameter int PAGES_PER_PLANE = 1024,
  parameter int PROG_AE_CYC = flash_prot_pkg::PROG_AE_CYC,
  parameter int PROG_CYC = flash_prot_pkg::PROG_CYC,
  parameter int FULL_ERASE_CYC = flash_prot_pkg::FULL_ERASE_CYC,
  parameter int DEBOUNCE_CYC = flash_prot_pkg::DEBOUNCE_CYC
) (
  // clock and resets
  input wire logic mclk,
  input wire logic srst,
  input wire logic por,
  // pins
  input wire logic erase_pin,
  input wire logic test_mode_pin,
  input wire logic port_a_line0,
  input wire logic port_a_line1,
  // command port
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_src,
  input wire logic [3:0] cmd_code,
  input wire logic [flash_prot_pkg::PAGE_W-1:0] cmd_page,
  input wire logic [1:0] cmd_bit,
  output logic cmd_done,
  output logic cmd_abort,
  output logic cmd_refused,
  output logic lock_irq,
  // memory access decode
  input wire logic acc_valid,
  input wire logic [1:0] acc_src,
  input wire logic [31:0] acc_addr,
  output logic acc_sram,
  output logic acc_rom,
  output logic acc_flash,
  output logic acc_refused,
  // status
  output logic [NUM_PLANES-1:0] plane_busy,
  output logic [LOCK_BITS-1:0] lock_bits,
  output logic [2:0] general_purpose_nv_bit,
  output logic brownout_detector_en,
  output logic brownout_reset_en,
  output logic boot_from_flash,
  output logic remapped,
  output logic security_set,
  output logic fast_prog_mode,
  output logic [flash_prot_pkg::CAL_W-1:0] cal_bits
);
  localparam int RW = $clog2(LOCK_BITS);
  localparam int PLANE_BIT = $clog2(PAGES_PER_PLANE);
  localparam int CW = flash_prot_pkg::CNT_W;

  typedef struct packed {
    logic [2:0] gp;
    logic [LOCK_BITS-1:0] lock;
    logic [flash_prot_pkg::CAL_W-1:0] cal;
    logic sec;
    logic armed;
    logic remap;
    logic boot_flash;
    logic fast_mode;
    flash_prot_pkg::plane_st_t [NUM_PLANES-1:0] pst;
    logic [NUM_PLANES-1:0][CW-1:0] cnt;
    logic [NUM_PLANES-1:0] full_op;
    logic done;
    logic abort;
    logic irq;
    logic refused;
    logic a_sram;
    logic a_rom;
    logic a_flash;
    logic a_refused;
  } state_t;
  state_t st_ff;
  state_t nxt_st;
  logic erase_event;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic plane_of(input logic [flash_prot_pkg::PAGE_W-1:0] page);
    plane_of = (NUM_PLANES > 1) ? page[PLANE_BIT] : 1'b0;
  endfunction : plane_of

  function automatic logic [RW-1:0] region_of(input logic [flash_prot_pkg::PAGE_W-1:0] page);
    region_of = page[flash_prot_pkg::REGION_SHIFT +: RW]; // RULE7
  endfunction : region_of

  function automatic logic is_write(input logic [3:0] code);
    is_write = (code == flash_prot_pkg::CMD_PROG_AE) || (code == flash_prot_pkg::CMD_PROG) ||
               (code == flash_prot_pkg::CMD_PAGE_ERASE);
  endfunction : is_write

  function automatic logic src_blocked(input logic [1:0] src, input logic sec, input logic fmode);
    src_blocked = (sec && src != flash_prot_pkg::SRC_CPU) ||
                  (src == flash_prot_pkg::SRC_FAST && !fmode);
  endfunction : src_blocked

  erase_debounce #(
    .HOLD_CYC(DEBOUNCE_CYC)
  ) u_erase_debounce (
    .mclk(mclk),
    .srst(srst),
    .erase_pin(erase_pin),
    .erase_event(erase_event)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic pl;
    logic [RW-1:0] rg;
    logic all_idle;
    logic [11:0] area;
    logic to_flash;
    logic acc_pl;
    pl = plane_of(cmd_page);
    rg = region_of(cmd_page);
    all_idle = 1'b1;
    area = acc_addr[31:20];
    to_flash = 1'b0;
    acc_pl = 1'b0;
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    nxt_st.abort = 1'b0;
    nxt_st.irq = 1'b0;
    nxt_st.refused = 1'b0;
    nxt_st.a_sram = 1'b0;
    nxt_st.a_rom = 1'b0;
    nxt_st.a_flash = 1'b0;
    nxt_st.a_refused = 1'b0;
    nxt_st.fast_mode = test_mode_pin && port_a_line0 && port_a_line1; // RULE19
    // busy countdown per plane
    for (int p = 0; p < NUM_PLANES; p++) begin
      case (st_ff.pst[p])
        flash_prot_pkg::PL_IDLE: begin
        end
        flash_prot_pkg::PL_BUSY: begin
          all_idle = 1'b0;
          if (st_ff.cnt[p] == '0) begin
            nxt_st.pst[p] = flash_prot_pkg::PL_IDLE;
            nxt_st.done = 1'b1;
            nxt_st.full_op[p] = 1'b0;
            if (st_ff.full_op[p] && st_ff.armed) begin
              nxt_st.sec = 1'b0; // RULE14
              nxt_st.armed = 1'b0;
            end
          end else begin
            nxt_st.cnt[p] = st_ff.cnt[p] - 1'b1;
          end
        end
        default: nxt_st.pst[p] = flash_prot_pkg::PL_IDLE;
      endcase
    end
    // commands
    if (cmd_valid) begin
      if (src_blocked(cmd_src, st_ff.sec, st_ff.fast_mode)) begin
        nxt_st.refused = 1'b1; // RULE13
      end else begin
        case (cmd_code) // RULE20
          flash_prot_pkg::CMD_READ: begin
            nxt_st.done = (st_ff.pst[pl] == flash_prot_pkg::PL_IDLE); // RULE12
            nxt_st.refused = (st_ff.pst[pl] != flash_prot_pkg::PL_IDLE);
          end
          flash_prot_pkg::CMD_PROG_AE, flash_prot_pkg::CMD_PROG, flash_prot_pkg::CMD_PAGE_ERASE: begin
            if (st_ff.pst[pl] != flash_prot_pkg::PL_IDLE) begin
              nxt_st.refused = 1'b1;
            end else if (st_ff.lock[rg]) begin
              nxt_st.abort = 1'b1; // RULE8
              nxt_st.irq = 1'b1;
            end else begin
              nxt_st.pst[pl] = flash_prot_pkg::PL_BUSY;
              nxt_st.cnt[pl] = (cmd_code == flash_prot_pkg::CMD_PROG_AE) ?
                               CW'(PROG_AE_CYC - 1) : CW'(PROG_CYC - 1); // RULE21
            end
          end
          flash_prot_pkg::CMD_FULL_ERASE: begin
            if (!all_idle) begin
              nxt_st.refused = 1'b1;
            end else begin
              for (int p = 0; p < NUM_PLANES; p++) begin
                nxt_st.pst[p] = flash_prot_pkg::PL_BUSY;
                nxt_st.cnt[p] = CW'(FULL_ERASE_CYC - 1); // RULE21
                nxt_st.full_op[p] = 1'b1;
              end
            end
          end
          flash_prot_pkg::CMD_SET_LOCK: begin
            nxt_st.lock[rg] = 1'b1; // RULE9 RULE11
            nxt_st.done = 1'b1;
          end
          flash_prot_pkg::CMD_CLR_LOCK: begin
            nxt_st.lock[rg] = 1'b0; // RULE9
            nxt_st.done = 1'b1;
          end
          flash_prot_pkg::CMD_SET_GP, flash_prot_pkg::CMD_CLR_GP: begin
            if (cmd_bit == 2'h3) begin
              nxt_st.refused = 1'b1;
            end else begin
              nxt_st.gp[cmd_bit] = (cmd_code == flash_prot_pkg::CMD_SET_GP); // RULE5
              nxt_st.done = 1'b1;
            end
          end
          flash_prot_pkg::CMD_SET_SEC: begin
            nxt_st.sec = 1'b1; // RULE14
            nxt_st.done = 1'b1;
          end
          flash_prot_pkg::CMD_REMAP: begin
            // a refused remap must not undo an earlier one
            if (cmd_src == flash_prot_pkg::SRC_CPU) begin
              nxt_st.remap = 1'b1; // RULE23
              nxt_st.done = 1'b1;
            end else begin
              nxt_st.refused = 1'b1;
            end
          end
          default: nxt_st.refused = 1'b1;
        endcase
      end
    end
    // erase pin event overrides commands of the same cycle
    if (erase_event) begin
      nxt_st.gp = 3'h0; // RULE6 RULE16 RULE17
      nxt_st.lock = '0; // RULE10
      nxt_st.armed = 1'b1;
      for (int p = 0; p < NUM_PLANES; p++) begin
        nxt_st.pst[p] = flash_prot_pkg::PL_BUSY;
        nxt_st.cnt[p] = CW'(FULL_ERASE_CYC - 1);
        nxt_st.full_op[p] = 1'b1;
      end
    end
    // address decode
    if (acc_valid) begin
      acc_pl = plane_of(acc_addr[flash_prot_pkg::PAGE_SHIFT +: flash_prot_pkg::PAGE_W]);
      if (area == flash_prot_pkg::AREA_ROM) begin
        nxt_st.a_rom = 1'b1; // RULE2
      end else if (area == flash_prot_pkg::AREA_SRAM) begin
        nxt_st.a_sram = 1'b1; // RULE1
      end else if (area == flash_prot_pkg::AREA_FLASH) begin
        to_flash = 1'b1; // RULE3
      end else if (area == flash_prot_pkg::AREA_ZERO) begin
        if (st_ff.remap) begin
          nxt_st.a_sram = 1'b1; // RULE1
        end else if (st_ff.boot_flash) begin
          to_flash = 1'b1; // RULE3 RULE4
        end else begin
          nxt_st.a_rom = 1'b1; // RULE4
        end
      end else begin
        nxt_st.a_refused = 1'b1;
      end
      if (to_flash) begin
        if (src_blocked(acc_src, st_ff.sec, st_ff.fast_mode) ||
            st_ff.pst[acc_pl] != flash_prot_pkg::PL_IDLE) begin
          nxt_st.a_refused = 1'b1; // RULE13 RULE12
        end else begin
          nxt_st.a_flash = 1'b1;
        end
      end
    end
    // resets: power-on loads nonvolatile defaults, system reset spares them
    if (por || srst) begin
      nxt_st.remap = 1'b0;
      nxt_st.boot_flash = st_ff.gp[flash_prot_pkg::GP_BOOT]; // RULE23
      nxt_st.fast_mode = 1'b0;
      nxt_st.done = 1'b0;
      nxt_st.abort = 1'b0;
      nxt_st.irq = 1'b0;
      nxt_st.refused = 1'b0;
      nxt_st.a_sram = 1'b0;
      nxt_st.a_rom = 1'b0;
      nxt_st.a_flash = 1'b0;
      nxt_st.a_refused = 1'b0;
      nxt_st.cnt = '0;
      nxt_st.full_op = '0;
      for (int p = 0; p < NUM_PLANES; p++) begin
        nxt_st.pst[p] = flash_prot_pkg::PL_IDLE;
      end
    end
    if (por) begin
      nxt_st.gp = 3'h0;
      nxt_st.lock = '0;
      nxt_st.sec = 1'b0;
      nxt_st.armed = 1'b0;
      nxt_st.boot_flash = 1'b0;
    end
    nxt_st.cal = flash_prot_pkg::CAL_DEFAULT; // RULE18
  end

  always_ff @(posedge mclk) begin
    st_ff <= nxt_st;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign cmd_done = st_ff.done;
  assign cmd_abort = st_ff.abort;
  assign cmd_refused = st_ff.refused;
  assign lock_irq = st_ff.irq;
  assign acc_sram = st_ff.a_sram;
  assign acc_rom = st_ff.a_rom;
  assign acc_flash = st_ff.a_flash;
  assign acc_refused = st_ff.a_refused;
  assign lock_bits = st_ff.lock;
  assign general_purpose_nv_bit = st_ff.gp;
  assign brownout_detector_en = st_ff.gp[flash_prot_pkg::GP_BROWN_EN]; // RULE16
  assign brownout_reset_en = st_ff.gp[flash_prot_pkg::GP_BROWN_RST]; // RULE17
  assign boot_from_flash = st_ff.boot_flash;
  assign remapped = st_ff.remap;
  assign security_set = st_ff.sec;
  assign fast_prog_mode = st_ff.fast_mode;
  assign cal_bits = st_ff.cal;
  always_comb begin
    for (int p = 0; p < NUM_PLANES; p++) begin
      plane_busy[p] = (st_ff.pst[p] == flash_prot_pkg::PL_BUSY);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst || por);

  sequence s_cpu_write_idle;
    cmd_valid && cmd_src == flash_prot_pkg::SRC_CPU && is_write(cmd_code) && !erase_event &&
    st_ff.pst[plane_of(cmd_page)] == flash_prot_pkg::PL_IDLE;
  endsequence
  sequence s_locked_write;
    s_cpu_write_idle and st_ff.lock[region_of(cmd_page)];
  endsequence

  a_rom_fixed: assert property (acc_valid && acc_addr[31:20] == flash_prot_pkg::AREA_ROM |=> acc_rom) // RULE2
    else $error("rom not selected at its fixed base");
  a_sram_zero: assert property (acc_valid && acc_addr[31:20] == 12'h000 && remapped |=> acc_sram) // RULE1
    else $error("sram not at zero after remap");
  a_flash_zero: assert property (acc_valid && acc_addr[31:20] == 12'h000 && !remapped && boot_from_flash // RULE3
    |=> acc_flash || acc_refused)
    else $error("flash alias at zero missing");
  a_rom_zero: assert property (acc_valid && acc_addr[31:20] == 12'h000 && !remapped && !boot_from_flash // RULE4
    |=> acc_rom)
    else $error("rom not at zero for rom boot");
  a_locked_abort: assert property (s_locked_write |=> cmd_abort && lock_irq && // RULE8
    !plane_busy[plane_of($past(cmd_page))])
    else $error("locked write not aborted");
  a_prog_busy: assert property (s_cpu_write_idle and !st_ff.lock[region_of(cmd_page)] and // RULE21
    cmd_code == flash_prot_pkg::CMD_PROG_AE |=> plane_busy[plane_of($past(cmd_page))] ##1
    plane_busy[plane_of($past(cmd_page, 2))] ##1 plane_busy[plane_of($past(cmd_page, 3))])
    else $error("page program did not hold plane busy");
  a_sec_refuse: assert property (acc_valid && security_set && acc_src != flash_prot_pkg::SRC_CPU && // RULE13
    acc_addr[31:20] == flash_prot_pkg::AREA_FLASH |=> acc_refused && !acc_flash)
    else $error("secured flash access not refused");
  a_erase_clear: assert property (erase_event |=> general_purpose_nv_bit == 3'h0 && lock_bits == '0) // RULE10
    else $error("erase pin did not clear bits");
  a_sec_hold: assert property ($fell(security_set) |-> $past(st_ff.armed)) // RULE14
    else $error("security cleared without erase pin");
  a_cal_stable: assert property (##1 $stable(cal_bits)) // RULE18
    else $error("calibration bits changed");
  a_set_lock: assert property (cmd_valid && cmd_src == flash_prot_pkg::SRC_CPU && !erase_event && // RULE9
    cmd_code == flash_prot_pkg::CMD_SET_LOCK |=> lock_bits[region_of($past(cmd_page))])
    else $error("set lock did not lock region");
endmodule : flash_protection_boot_map
`default_nettype wire

// *** design/flash_prot_pkg.sv ***
// constants, types and timing for the flash protection and boot map block
// How it works
// RULE1: sram decodes at 0x0020_0000 always, and also at zero once remapped
// RULE2: boot rom always decodes at 0x0030_0000
// RULE3: flash decodes at 0x0010_0000, aliased at zero before remap if bit 2 set
// RULE4: bit 2 high boots from flash, low puts rom at zero
// RULE5: set and clear commands write the addressed general purpose bit
// RULE6: a debounced erase pin clears general purpose bit 2
// RULE7: each lock region is 64 pages of 256 bytes; lock count is a parameter
// RULE8: program or erase into a locked region aborts and raises an interrupt pulse
// RULE9: set lock and clear lock commands protect or unprotect one region
// RULE10: a debounced erase pin clears every lock bit
// RULE11: in two-plane builds each plane owns half the lock bits, all visible
// RULE12: reads of one plane proceed while the other plane is busy
// RULE13: with security set, emulator and fast port flash accesses are refused
// RULE14: security sets only by command, clears after erase pin then full erase
// RULE15: the outside party holds the erase pin longer than 220 ms
// RULE16: general purpose bit 0 enables the brownout detector; erase clears it
// RULE17: general purpose bit 1 enables brownout reset; erase clears it
// RULE18: eight calibration bits ignore commands and the erase pin
// RULE19: fast programming mode needs test pin and port a lines 0 and 1 high
// RULE20: fast port takes read, program, erase, full erase, lock, unlock, protect
// RULE21: busy lasts 6 ms program with erase, 3 ms without, 15 ms full erase
// RULE22: erase pin assertions shorter than 200 ms are ignored
// RULE23: remap holds until system reset; flash alias uses bit 2 seen at reset
package flash_prot_pkg;
  // ----------------------------------------
  // memory map
  // ----------------------------------------
  localparam logic [11:0] AREA_ZERO = 12'h000;
  localparam logic [11:0] AREA_FLASH = 12'h001;
  localparam logic [11:0] AREA_SRAM = 12'h002;
  localparam logic [11:0] AREA_ROM = 12'h003;
  localparam int PAGE_SHIFT = 8;
  localparam int PAGE_W = 11;
  localparam int REGION_SHIFT = 6;
  localparam int GP_BOOT = 2;
  localparam int GP_BROWN_RST = 1;
  localparam int GP_BROWN_EN = 0;
  localparam int CAL_W = 8;
  localparam logic [7:0] CAL_DEFAULT = 8'h5a; // arbitrary
  // ----------------------------------------
  // sources and commands
  // ----------------------------------------
  localparam logic [1:0] SRC_CPU = 2'h0;
  localparam logic [1:0] SRC_EMUL = 2'h1;
  localparam logic [1:0] SRC_FAST = 2'h2;
  localparam logic [3:0] CMD_READ = 4'h0;
  localparam logic [3:0] CMD_PROG_AE = 4'h1;
  localparam logic [3:0] CMD_PROG = 4'h2;
  localparam logic [3:0] CMD_PAGE_ERASE = 4'h3;
  localparam logic [3:0] CMD_FULL_ERASE = 4'h4;
  localparam logic [3:0] CMD_SET_LOCK = 4'h5;
  localparam logic [3:0] CMD_CLR_LOCK = 4'h6;
  localparam logic [3:0] CMD_SET_GP = 4'h7;
  localparam logic [3:0] CMD_CLR_GP = 4'h8;
  localparam logic [3:0] CMD_SET_SEC = 4'h9;
  localparam logic [3:0] CMD_REMAP = 4'ha;
  typedef enum logic [1:0] {PL_IDLE = 2'b01, PL_BUSY = 2'b10} plane_st_t;
  // ----------------------------------------
  // timing, 40 MHz master clock
  // ----------------------------------------
  localparam int CLK_KHZ = 40000;
  localparam int PROG_AE_MS = 6;
  localparam int PROG_MS = 3;
  localparam int FULL_ERASE_MS = 15;
  localparam int DEBOUNCE_MS = 200;
  localparam int ERASE_HOLD_MS = 220;
  localparam int PROG_AE_CYC = PROG_AE_MS * CLK_KHZ;
  localparam int PROG_CYC = PROG_MS * CLK_KHZ;
  localparam int FULL_ERASE_CYC = FULL_ERASE_MS * CLK_KHZ;
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
  localparam int CNT_W = 24;
endpackage : flash_prot_pkg

// *** design/erase_debounce.sv ***
// erase pin filter: one pulse per assertion held long enough
`timescale 1ns/1ps
`default_nettype none
module erase_debounce #(
  parameter int HOLD_CYC = flash_prot_pkg::DEBOUNCE_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // pin and event
  input wire logic erase_pin,
  output logic erase_event
);
  typedef struct packed {
    logic [flash_prot_pkg::CNT_W-1:0] cnt;
    logic fired;
    logic pulse;
  } deb_t;
  deb_t st_ff;
  deb_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.pulse = 1'b0;
    if (srst || !erase_pin) begin
      nxt_st.cnt = '0;
      nxt_st.fired = 1'b0;
    end else if (!st_ff.fired) begin
      if (st_ff.cnt == flash_prot_pkg::CNT_W'(HOLD_CYC - 1)) begin // RULE22
        nxt_st.fired = 1'b1;
        nxt_st.pulse = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    st_ff <= nxt_st;
  end

  assign erase_event = st_ff.pulse;
endmodule : erase_debounce
`default_nettype wire

// *** sim/flash_cmd_source.sv ***
// model of the software or programmer driving commands and pins
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_source (
  // clock
  input wire logic mclk,
  // command lines
  output logic cmd_valid,
  output logic [1:0] cmd_src,
  output logic [3:0] cmd_code,
  output logic [flash_prot_pkg::PAGE_W-1:0] cmd_page,
  output logic [1:0] cmd_bit,
  // pins
  output logic erase_pin,
  output logic test_mode_pin,
  output logic port_a_line0,
  output logic port_a_line1
);
  initial begin
    {cmd_valid, cmd_src, cmd_code, cmd_page, cmd_bit} = '0;
    {erase_pin, test_mode_pin, port_a_line0, port_a_line1} = '0;
  end
  // one-cycle strobe; released lines wander
  task automatic send(input logic [1:0] s, input logic [3:0] c, input logic [10:0] p, input logic [1:0] b);
    @(negedge mclk);
    cmd_valid <= 1'b1;
    {cmd_src, cmd_code, cmd_page, cmd_bit} <= {s, c, p, b};
    @(negedge mclk);
    cmd_valid <= 1'b0;
    {cmd_src, cmd_code, cmd_page, cmd_bit} <= ~{s, c, p, b};
  endtask : send
  task automatic hold_erase(input int n);
    @(negedge mclk);
    erase_pin <= 1'b1;
    repeat (n) @(negedge mclk);
    erase_pin <= 1'b0;
  endtask : hold_erase
  task automatic fast(input logic on);
    @(negedge mclk);
    {test_mode_pin, port_a_line0, port_a_line1} <= {3{on}};
  endtask : fast
endmodule : flash_cmd_source
`default_nettype wire

// *** sim/flash_protection_boot_map_tb.sv ***
// self-checking bench for flash protection and boot map
`timescale 1ns/1ps
`default_nettype none
module flash_protection_boot_map_tb;
  localparam int AE = 20;
  localparam int PG = 10;
  localparam int FE = 30;
  localparam int DB = 8;
  localparam logic [3:0] FC [8] = '{flash_prot_pkg::CMD_READ, flash_prot_pkg::CMD_PROG_AE, flash_prot_pkg::CMD_PROG,
    flash_prot_pkg::CMD_PAGE_ERASE, flash_prot_pkg::CMD_FULL_ERASE, flash_prot_pkg::CMD_SET_LOCK,
    flash_prot_pkg::CMD_CLR_LOCK, flash_prot_pkg::CMD_SET_SEC};
  localparam int FL [8] = '{1, AE + 1, PG + 1, PG + 1, FE + 1, 1, 1, 1};
  localparam logic [1:0] CPU = flash_prot_pkg::SRC_CPU;
  localparam logic [1:0] EMU = flash_prot_pkg::SRC_EMUL;
  localparam logic [1:0] FST = flash_prot_pkg::SRC_FAST;
  logic mclk, srst, por, erase_pin, test_mode_pin, port_a_line0, port_a_line1;
  logic cmd_valid, cmd_done, cmd_abort, cmd_refused, lock_irq;
  logic [1:0] cmd_src, cmd_bit, acc_src, res;
  logic [3:0] cmd_code;
  logic [10:0] cmd_page;
  logic acc_valid, acc_sram, acc_rom, acc_flash, acc_refused, irq_seen, busy_seen;
  logic [31:0] acc_addr;
  logic [0:0] plane_busy;
  logic [15:0] lock_bits;
  logic [2:0] general_purpose_nv_bit;
  logic brownout_detector_en, brownout_reset_en, boot_from_flash, remapped, security_set, fast_prog_mode;
  logic [7:0] cal_bits;
  int num_errors, checks, cycles, cyc;
  flash_protection_boot_map #(.LOCK_BITS(16), .NUM_PLANES(1), .PAGES_PER_PLANE(1024), .PROG_AE_CYC(AE),
    .PROG_CYC(PG), .FULL_ERASE_CYC(FE), .DEBOUNCE_CYC(DB)) dut (.*);
  flash_cmd_source pm (.*);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // issue a command, wait for its answer; res 1 done, 2 abort, 3 refused
  task automatic cx(input logic [1:0] s, input logic [3:0] c, input logic [10:0] p, input logic [1:0] b,
                    input logic [1:0] er, input int ec);
    pm.send(s, c, p, b);
    cyc = 1;
    busy_seen = plane_busy[0];
    while ((cmd_done | cmd_abort | cmd_refused) !== 1'b1 && cyc < 200) begin
      @(negedge mclk);
      cyc++;
    end
    res = {cmd_abort | cmd_refused, cmd_done | cmd_refused};
    irq_seen = lock_irq;
    chk("answer", res, er);
    chk("latency", cyc, ec);
  endtask : cx
  // decode result is {sram, rom, flash, refused}
  task automatic ax(input logic [1:0] s, input logic [31:0] a, input logic [3:0] exp);
    @(negedge mclk);
    {acc_valid, acc_src, acc_addr} <= {1'b1, s, a};
    @(negedge mclk);
    {acc_valid, acc_addr} <= {1'b0, ~a};
    chk("decode", {acc_sram, acc_rom, acc_flash, acc_refused}, exp);
  endtask : ax
  task automatic rst(input int n);
    @(negedge mclk);
    srst <= 1'b1;
    repeat (n) @(negedge mclk);
    srst <= 1'b0;
  endtask : rst
  task automatic t_reset_map();
    chk("cal", cal_bits, flash_prot_pkg::CAL_DEFAULT);
    chk("gp", general_purpose_nv_bit, 3'h0);
    ax(CPU, 32'h0000_0040, 4'b0100);
    ax(CPU, 32'h0030_0000, 4'b0100);
    ax(CPU, 32'h0010_0000, 4'b0010);
    ax(CPU, 32'h0020_0000, 4'b1000);
    ax(EMU, 32'h0010_0000, 4'b0010);
    ax(CPU, 32'h0040_0000, 4'b0001);
  endtask : t_reset_map
  task automatic t_gp_boot();
    for (int i = 0; i < 3; i++) cx(CPU, flash_prot_pkg::CMD_SET_GP, 11'h0, i[1:0], 2'd1, 1);
    chk("brown_en", brownout_detector_en, 1'b1);
    chk("brown_rst", brownout_reset_en, 1'b1);
    ax(CPU, 32'h0, 4'b0100);
    cx(CPU, flash_prot_pkg::CMD_SET_GP, 11'h0, 2'd3, 2'd3, 1);
    cx(CPU, flash_prot_pkg::CMD_CLR_GP, 11'h0, 2'd0, 2'd1, 1);
    chk("brown_en", brownout_detector_en, 1'b0);
    rst(2);
    chk("boot", boot_from_flash, 1'b1);
    chk("gp", general_purpose_nv_bit, 3'h6);
    ax(CPU, 32'h0, 4'b0010);
    cx(EMU, flash_prot_pkg::CMD_REMAP, 11'h0, 2'd0, 2'd3, 1);
    ax(CPU, 32'h0, 4'b0010);
    cx(CPU, flash_prot_pkg::CMD_REMAP, 11'h0, 2'd0, 2'd1, 1);
    ax(CPU, 32'h0, 4'b1000);
    cx(EMU, flash_prot_pkg::CMD_REMAP, 11'h0, 2'd0, 2'd3, 1);
    ax(CPU, 32'h0, 4'b1000);
    ax(CPU, 32'h0010_0000, 4'b0010);
    rst(1);
    chk("remap", remapped, 1'b0);
    ax(CPU, 32'h0, 4'b0010);
  endtask : t_gp_boot
  task automatic t_lock();
    cx(CPU, flash_prot_pkg::CMD_SET_LOCK, 11'h3c0, 2'd0, 2'd1, 1);
    chk("locks", lock_bits, 16'h8000);
    cx(CPU, flash_prot_pkg::CMD_PROG_AE, 11'h3ff, 2'd0, 2'd2, 1);
    chk("irq", irq_seen, 1'b1);
    cx(CPU, flash_prot_pkg::CMD_PAGE_ERASE, 11'h3c0, 2'd0, 2'd2, 1);
    cx(CPU, flash_prot_pkg::CMD_PROG_AE, 11'h3bf, 2'd0, 2'd1, AE + 1);
    chk("busy", busy_seen, 1'b1);
    chk("irq", irq_seen, 1'b0);
    cx(CPU, flash_prot_pkg::CMD_CLR_LOCK, 11'h3c0, 2'd0, 2'd1, 1);
    chk("locks", lock_bits, 16'h0);
    cx(CPU, flash_prot_pkg::CMD_PROG, 11'h3ff, 2'd0, 2'd1, PG + 1);
  endtask : t_lock
  task automatic t_security();
    cx(CPU, flash_prot_pkg::CMD_SET_LOCK, 11'h000, 2'd0, 2'd1, 1);
    cx(CPU, flash_prot_pkg::CMD_SET_SEC, 11'h0, 2'd0, 2'd1, 1);
    ax(EMU, 32'h0010_0000, 4'b0001);
    ax(CPU, 32'h0010_0000, 4'b0010);
    cx(EMU, flash_prot_pkg::CMD_READ, 11'h0, 2'd0, 2'd3, 1);
    cx(CPU, flash_prot_pkg::CMD_FULL_ERASE, 11'h0, 2'd0, 2'd1, FE + 1);
    chk("sec", security_set, 1'b1);
    pm.hold_erase(DB / 2);
    repeat (4) @(negedge mclk);
    chk("gp", general_purpose_nv_bit, 3'h6);
    pm.hold_erase(DB + 4);
    chk("gp", general_purpose_nv_bit, 3'h0);
    chk("brown", {brownout_reset_en, brownout_detector_en}, 2'b00);
    chk("locks", lock_bits, 16'h0);
    chk("cal", cal_bits, flash_prot_pkg::CAL_DEFAULT);
    chk("busy", plane_busy, 1'b1);
    cyc = 0;
    while (plane_busy !== 1'b0 && cyc < 100) begin
      @(negedge mclk);
      cyc++;
    end
    @(negedge mclk);
    chk("sec", security_set, 1'b0);
    ax(EMU, 32'h0010_0000, 4'b0010);
  endtask : t_security
  task automatic t_fast();
    cx(FST, flash_prot_pkg::CMD_READ, 11'h0, 2'd0, 2'd3, 1);
    pm.fast(1'b1);
    @(negedge mclk);
    chk("fast", fast_prog_mode, 1'b1);
    for (int i = 0; i < 8; i++) cx(FST, FC[i], 11'h040, 2'd0, 2'd1, FL[i]);
    chk("sec", security_set, 1'b1);
    cx(FST, flash_prot_pkg::CMD_READ, 11'h0, 2'd0, 2'd3, 1);
    pm.fast(1'b0);
  endtask : t_fast
  initial begin
    {srst, por, acc_valid, acc_src, acc_addr} = {1'b1, 1'b1, 35'h0};
    {num_errors, checks, cycles} = {32'h0, 32'h0, 32'h0};
    repeat (12) @(negedge mclk);
    {srst, por} <= 2'b00;
    @(negedge mclk);
    t_reset_map();
    t_gp_boot();
    t_lock();
    t_security();
    t_fast();
    test_done();
  end
endmodule : flash_protection_boot_map_tb
`default_nettype wire
